// [dpsd_frame.sv]
// Diagnostic frame builder of a fieldbus slave, with its Wishbone register file.
// Assumes the protocol engine sits on the same clock and drains bytes with valid/ready.
//
// Overview of operation
// - Send frame on request; flag own errors
// - Bytes 0 to 5 hold standard part
// - Bytes 6 to 15 device part, 8-10 reserved
// - Station status one: fixed zeros, five flags
// - Station status two: flags, bit2 one
// - Station status three: bit7 overflow only
// - Byte 3 holds parametrizing master address
// - CPU writes user bytes 11-15
// - Byte 6 is length ten, code zero
// - Byte 7 error codes or 40h
// - Status 0 to 1 starts; 03h ignored
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module dpsd_frame
  import dpsd_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic diag_req_i,
  input wire logic not_ready_i,
  input wire logic cfg_fault_i,
  input wire logic unsupported_i,
  input wire logic bad_param_i,
  input wire logic param_req_i,
  input wire logic static_diag_i,
  input wire logic watchdog_on_i,
  input wire logic freeze_rx_i,
  input wire logic sync_rx_i,
  input wire logic overflow_i,
  input wire logic [7:0] master_addr_i,
  input wire logic [2:0] err_code_i,
  input wire logic frame_ready_i,
  output logic frame_valid_o,
  output logic [7:0] frame_byte_o,
  output logic frame_last_o,
  output logic diag_pending_o,
  output logic irq_o
);
  // ==========================================================================
  // Bus slave
  // ==========================================================================
  logic phase_r;
  logic bus_req;
  logic bus_go;
  logic wr_go;
  logic [1:0] diag_stat_r;
  logic [15:0] ident_r;
  logic [2:0] err_code_r;
  logic [DPSD_IRQ_N-1:0] irq_stat;
  logic [DPSD_IRQ_N-1:0] irq_mask;
  logic [DPSD_IRQ_N-1:0] irq_event;
  logic [7:0] user_bus_q;
  logic [7:0] user_frm_q;
  logic user_hit;
  logic [2:0] user_idx;
  logic [7:0] msg_code;
  logic [31:0] rd_mux;
  logic start_diag;
  logic ignore_wr;
  logic err_rise;
  dpsd_state_t state_r;
  logic [3:0] idx_r;
  logic frame_done;
  logic [7:0] byte_mux;

  // Reads of the user store take a registered memory access, so every access
  // gets two cycles; the uniform latency keeps the master side simple.
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_go = bus_req & phase_r;
  assign wr_go = bus_go & wb_we_i;
  assign user_hit = wb_adr_i >= DPSD_OFS_USER0 && wb_adr_i <= DPSD_OFS_USER4
    && wb_adr_i[1:0] == 2'h0;
  assign user_idx = 3'(wb_adr_i[4:2]);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_r <= 1'b0;
      wb_ack_o <= 1'b0;
    end else if (ce_i) begin
      phase_r <= bus_req & ~phase_r;
      wb_ack_o <= bus_go;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      DPSD_OFS_DIAG_STAT: rd_mux = {30'h0000_0000, diag_stat_r};
      DPSD_OFS_IDENT: rd_mux = {16'h0000, ident_r};
      DPSD_OFS_STATUS: rd_mux = {16'h0000, msg_code, 5'h00,
        state_r != DPSD_IDLE, diag_pending_o, diag_stat_r[DPSD_DS_VALID_BIT]};
      DPSD_OFS_IRQ_STAT: rd_mux = {28'h000_0000, irq_stat};
      DPSD_OFS_IRQ_MASK: rd_mux = {28'h000_0000, irq_mask};
      default: rd_mux = user_hit ? {24'h00_0000, user_bus_q} : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i && bus_go) begin
      wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_mux;
    end
  end

  // ==========================================================================
  // Diagnostic status byte and identification
  // ==========================================================================
  assign ignore_wr = wr_go && wb_sel_i[0] && wb_adr_i == DPSD_OFS_DIAG_STAT
    && wb_dat_i[7:0] == DPSD_DS_IGNORED;
  assign start_diag = wr_go && wb_sel_i[0] && wb_adr_i == DPSD_OFS_DIAG_STAT
    && !ignore_wr && !diag_stat_r[DPSD_DS_VALID_BIT] && wb_dat_i[DPSD_DS_VALID_BIT];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_stat_r <= DPSD_DS_RESET;
    end else if (ce_i && wr_go && wb_sel_i[0] && wb_adr_i == DPSD_OFS_DIAG_STAT
        && !ignore_wr) begin
      diag_stat_r <= wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ident_r <= DPSD_IDENT_RESET;
    end else if (ce_i && wr_go && wb_adr_i == DPSD_OFS_IDENT) begin
      if (wb_sel_i[0]) begin
        ident_r[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        ident_r[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  dpsd_user_mem u_mem (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .wr_en_i(wr_go & wb_sel_i[0] & user_hit),
    .wr_addr_i(user_idx),
    .wr_data_i(wb_dat_i[7:0]),
    .rda_addr_i(user_idx),
    .rda_data_o(user_bus_q),
    .rdb_addr_i(3'(idx_r - DPSD_BYTE_USER0)),
    .rdb_data_o(user_frm_q)
  );

  // ==========================================================================
  // Own-initiative diagnostics and interrupts
  // ==========================================================================
  assign err_rise = err_code_i != 3'h0 && err_code_i != err_code_r;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_code_r <= 3'h0;
    end else if (ce_i) begin
      err_code_r <= err_code_i;
    end
  end

  // A new cause arriving as a frame completes keeps the request standing.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_pending_o <= 1'b0;
    end else if (ce_i) begin
      if (start_diag || err_rise) begin
        diag_pending_o <= 1'b1;
      end else if (frame_done) begin
        diag_pending_o <= 1'b0;
      end
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[DPSD_IRQ_SENT] = frame_done;
    irq_event[DPSD_IRQ_START] = start_diag;
    irq_event[DPSD_IRQ_IGNORED] = ignore_wr;
    irq_event[DPSD_IRQ_ERROR] = err_rise;
  end

  dpsd_irq #(
    .N(DPSD_IRQ_N)
  ) u_irq (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .event_i(irq_event),
    .clr_we_i(wr_go && wb_sel_i[0] && wb_adr_i == DPSD_OFS_IRQ_STAT),
    .mask_we_i(wr_go && wb_sel_i[0] && wb_adr_i == DPSD_OFS_IRQ_MASK),
    .wdata_i(wb_dat_i[DPSD_IRQ_N-1:0]),
    .status_o(irq_stat),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

  // ==========================================================================
  // Frame content
  // ==========================================================================
  always_comb begin
    case (err_code_i)
      3'h1: msg_code = DPSD_MSG_PRM_LEN;
      3'h2: msg_code = DPSD_MSG_CFG_LEN;
      3'h3: msg_code = DPSD_MSG_CFG_ENTRY;
      3'h4: msg_code = DPSD_MSG_BUF_CALC;
      3'h5: msg_code = DPSD_MSG_CFG_MISSING;
      3'h6: msg_code = DPSD_MSG_PRM_CFG;
      default: msg_code = diag_stat_r[DPSD_DS_VALID_BIT] ? DPSD_MSG_USER_VALID
        : DPSD_MSG_NONE;
    endcase
  end

  always_comb begin
    byte_mux = 8'h00;
    case (idx_r)
      4'h0: byte_mux = {1'b0, bad_param_i, 1'b0, unsupported_i,
        diag_stat_r[DPSD_DS_VALID_BIT] | (err_code_i != 3'h0),
        cfg_fault_i, not_ready_i, 1'b0};
      4'h1: byte_mux = {1'b0, 1'b0, sync_rx_i, freeze_rx_i, watchdog_on_i, 1'b1,
        static_diag_i, param_req_i};
      4'h2: byte_mux = {overflow_i, 7'h00};
      4'h3: byte_mux = master_addr_i;
      4'h4: byte_mux = ident_r[15:8];
      4'h5: byte_mux = ident_r[7:0];
      4'h6: byte_mux = {DPSD_DEV_CODE, DPSD_DEV_LEN};
      4'h7: byte_mux = msg_code;
      4'h8, 4'h9, 4'hA: byte_mux = 8'h00;
      default: byte_mux = user_frm_q;
    endcase
  end

  // ==========================================================================
  // Frame sequencer
  // ==========================================================================
  // A request that comes while a frame is on its way is not queued: the
  // engine asks again, which matches the poll-and-answer nature of the link.
  assign frame_done = state_r == DPSD_SEND && frame_ready_i && frame_last_o;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= DPSD_IDLE;
      idx_r <= 4'h0;
    end else if (ce_i) begin
      case (state_r)
        DPSD_IDLE: begin
          if (diag_req_i) begin
            state_r <= DPSD_FETCH;
            idx_r <= 4'h0;
          end
        end
        DPSD_FETCH: state_r <= DPSD_LOAD;
        DPSD_LOAD: state_r <= DPSD_SEND;
        DPSD_SEND: begin
          if (frame_ready_i) begin
            state_r <= frame_last_o ? DPSD_IDLE : DPSD_FETCH;
            idx_r <= frame_last_o ? 4'h0 : idx_r + 4'h1;
          end
        end
        default: state_r <= DPSD_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_valid_o <= 1'b0;
      frame_byte_o <= 8'h00;
      frame_last_o <= 1'b0;
    end else if (ce_i) begin
      if (state_r == DPSD_LOAD) begin
        frame_valid_o <= 1'b1;
        frame_byte_o <= byte_mux;
        frame_last_o <= idx_r == DPSD_BYTE_LAST;
      end else if (state_r == DPSD_SEND && frame_ready_i) begin
        frame_valid_o <= 1'b0;
        frame_last_o <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  chk_byte_six: assert property (ce_i && state_r == DPSD_LOAD && idx_r == 4'h6
    |=> frame_byte_o == 8'h0A) else $error("Byte six is not length ten.");
  chk_status_two: assert property (ce_i && state_r == DPSD_LOAD && idx_r == 4'h1
    |=> frame_byte_o[2] && !frame_byte_o[7]) else $error("Status two fixed bits wrong.");
  chk_status_one: assert property (ce_i && state_r == DPSD_LOAD && idx_r == 4'h0
    |=> (frame_byte_o & 8'hA1) == 8'h00) else $error("Status one fixed bits wrong.");
  chk_status_three: assert property (ce_i && state_r == DPSD_LOAD && idx_r == 4'h2
    |=> frame_byte_o[6:0] == 7'h00) else $error("Status three reserved bits set.");
  chk_ident_order: assert property (ce_i && state_r == DPSD_LOAD && idx_r == 4'h4
    |=> frame_byte_o == $past(ident_r[15:8])) else $error("Ident high byte not first.");
  chk_master_addr: assert property (ce_i && state_r == DPSD_LOAD && idx_r == 4'h3
    |=> frame_byte_o == $past(master_addr_i)) else $error("Master address wrong.");
  chk_msg_user: assert property (ce_i && state_r == DPSD_LOAD && idx_r == 4'h7
    && err_code_i == 3'h0 && diag_stat_r[0] |=> frame_byte_o == 8'h40)
    else $error("User valid code missing.");
  chk_ignore_03: assert property (ignore_wr && ce_i |=> $stable(diag_stat_r) && !diag_pending_o
    || $past(diag_pending_o) || $past(err_rise)) else $error("Status 03h not ignored.");
  chk_start_pend: assert property (start_diag && ce_i |=> diag_pending_o)
    else $error("Diagnostic start not flagged.");
  chk_req_frame: assert property (state_r == DPSD_IDLE && diag_req_i && ce_i
    |=> ##[1:2] frame_valid_o) else $error("Request not answered.");
  chk_frame_len: assert property (frame_valid_o && frame_last_o |-> idx_r == 4'hF)
    else $error("Frame not sixteen bytes.");

  cov_frame_done: cover property (frame_done);
  cov_user_start: cover property (start_diag ##[1:200] frame_done);
  cov_ignored: cover property (ignore_wr);
  cov_err_code: cover property (err_rise && err_code_i == 3'h6);

endmodule // dpsd_frame
`default_nettype wire

// [dpsd_pkg.sv]
// Package of the slave diagnostic frame block: register map, field positions, codes, states.
// Assumes a 32-bit classic Wishbone register bus and one 50 MHz system clock.
package dpsd_pkg;

  // ==========================================================================
  // Register map, byte addresses
  // ==========================================================================
  localparam logic [7:0] DPSD_OFS_DIAG_STAT = 8'h00;
  localparam logic [7:0] DPSD_OFS_IDENT = 8'h04;
  localparam logic [7:0] DPSD_OFS_STATUS = 8'h08;
  localparam logic [7:0] DPSD_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] DPSD_OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] DPSD_OFS_USER0 = 8'h20;
  localparam logic [7:0] DPSD_OFS_USER4 = 8'h30;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam int DPSD_DS_VALID_BIT = 0;
  localparam int DPSD_DS_DELETE_BIT = 1;
  localparam logic [7:0] DPSD_DS_IGNORED = 8'h03;
  localparam logic [1:0] DPSD_DS_RESET = 2'h0;
  // Identification number: the value is arbitrary.
  localparam logic [15:0] DPSD_IDENT_RESET = 16'h1234;
  localparam int DPSD_IRQ_N = 4;
  localparam int DPSD_IRQ_SENT = 0;
  localparam int DPSD_IRQ_START = 1;
  localparam int DPSD_IRQ_IGNORED = 2;
  localparam int DPSD_IRQ_ERROR = 3;

  // ==========================================================================
  // Frame layout
  // ==========================================================================
  localparam logic [3:0] DPSD_BYTE_LAST = 4'hF;
  localparam logic [3:0] DPSD_BYTE_USER0 = 4'hB;
  localparam logic [5:0] DPSD_DEV_LEN = 6'h0A;
  localparam logic [1:0] DPSD_DEV_CODE = 2'h0;
  localparam logic [7:0] DPSD_MSG_NONE = 8'h00;
  localparam logic [7:0] DPSD_MSG_PRM_LEN = 8'h12;
  localparam logic [7:0] DPSD_MSG_CFG_LEN = 8'h13;
  localparam logic [7:0] DPSD_MSG_CFG_ENTRY = 8'h14;
  localparam logic [7:0] DPSD_MSG_BUF_CALC = 8'h15;
  localparam logic [7:0] DPSD_MSG_CFG_MISSING = 8'h16;
  localparam logic [7:0] DPSD_MSG_PRM_CFG = 8'h17;
  localparam logic [7:0] DPSD_MSG_USER_VALID = 8'h40;

  typedef enum logic [1:0] {
    DPSD_IDLE = 2'h0,
    DPSD_FETCH = 2'h1,
    DPSD_LOAD = 2'h3,
    DPSD_SEND = 2'h2
  } dpsd_state_t;

endpackage

// [dpsd_user_mem.sv]
// Five-byte user diagnostic store with one write port and two registered read ports.
// Assumes all ports on one clock; reads return data one edge after the address.
`timescale 1ns/100ps
`default_nettype none
module dpsd_user_mem (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_en_i,
  input wire logic [2:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [2:0] rda_addr_i,
  output logic [7:0] rda_data_o,
  input wire logic [2:0] rdb_addr_i,
  output logic [7:0] rdb_data_o
);
  logic [7:0] mem_r [0:4];

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 5; i++) begin
        mem_r[i] <= 8'h00;
      end
    end else if (ce_i && wr_en_i && wr_addr_i < 3'h5) begin
      mem_r[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rda_data_o <= 8'h00;
      rdb_data_o <= 8'h00;
    end else if (ce_i) begin
      rda_data_o <= (rda_addr_i < 3'h5) ? mem_r[rda_addr_i] : 8'h00;
      rdb_data_o <= (rdb_addr_i < 3'h5) ? mem_r[rdb_addr_i] : 8'h00;
    end
  end
endmodule // dpsd_user_mem
`default_nettype wire

// [dpsd_irq.sv]
// Sticky event status with write-one-to-clear, a mask and one level interrupt.
// Assumes event pulses and bus writes on the same clock.
`timescale 1ns/100ps
`default_nettype none
module dpsd_irq #(
  parameter int N = 4
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [N-1:0] event_i,
  input wire logic clr_we_i,
  input wire logic mask_we_i,
  input wire logic [N-1:0] wdata_i,
  output logic [N-1:0] status_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);
  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
    end else if (ce_i) begin
      status_o <= (status_o & ~(clr_we_i ? wdata_i : '0)) | event_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_o <= '0;
    end else if (ce_i && mask_we_i) begin
      mask_o <= wdata_i;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(((status_o & ~(clr_we_i ? wdata_i : '0)) | event_i) & mask_o);
    end
  end
endmodule // dpsd_irq
`default_nettype wire

// [dpsd_engine_model.sv]
// Behavioural model of the protocol engine that polls the diagnostic frame builder.
// Assumes the builder's clock and reset; a poll is asked for by a one-cycle poll_i.
`timescale 1ns/100ps
`default_nettype none
module dpsd_engine_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic poll_i,
  input wire logic slow_i,
  input wire logic frame_valid_i,
  input wire logic [7:0] frame_byte_i,
  input wire logic frame_last_i,
  output logic diag_req_o,
  output logic frame_ready_o,
  output logic [7:0] rx_o [16],
  output logic [4:0] len_o,
  output int frames_o
);
  // ==========================================================================
  // Polling and byte collection
  // ==========================================================================
  logic [4:0] cnt_r;

  // A slow engine drops ready at random, so every byte must hold until taken.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_req_o <= 1'b0;
      frame_ready_o <= 1'b0;
      cnt_r <= 5'h00;
      len_o <= 5'h00;
      frames_o <= 0;
    end else begin
      diag_req_o <= poll_i;
      frame_ready_o <= slow_i ? 1'($urandom_range(1, 0)) : 1'b1;
      if (frame_valid_i && frame_ready_o) begin
        rx_o[cnt_r[3:0]] <= frame_byte_i;
        cnt_r <= frame_last_i ? 5'h00 : cnt_r + 5'h01;
        if (frame_last_i) begin
          len_o <= cnt_r + 5'h01;
          frames_o <= frames_o + 1;
        end
      end
    end
  end
endmodule // dpsd_engine_model
`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the diagnostic frame builder against a bench model.
// Assumes the package, the design and the engine model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top import dpsd_pkg::*; ;
  // ==========================================================================
  // Clock, stimulus and the device
  // ==========================================================================
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dw = 32'h0;
  logic [31:0] wb_dr;
  logic [31:0] q;
  logic wb_ack, diag_req, frame_ready, frame_valid, frame_last, pend, irq;
  logic poll = 1'b0;
  logic slow = 1'b0;
  logic [9:0] fl = 10'h000;
  logic [7:0] ma = 8'h00;
  logic [2:0] err = 3'h0;
  logic [7:0] frame_byte;
  logic [7:0] rx [16];
  logic [4:0] len;
  int frames;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int mu [5];
  logic [15:0] idn;
  logic uv = 1'b0;
  logic ce = 1'b1;

  always #10 clock_i = ~clock_i;

  dpsd_frame i_dpsd_frame (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack),
    .diag_req_i(diag_req), .not_ready_i(fl[0]), .cfg_fault_i(fl[1]),
    .unsupported_i(fl[2]), .bad_param_i(fl[3]), .param_req_i(fl[4]),
    .static_diag_i(fl[5]), .watchdog_on_i(fl[6]), .freeze_rx_i(fl[7]),
    .sync_rx_i(fl[8]), .overflow_i(fl[9]), .master_addr_i(ma), .err_code_i(err),
    .frame_ready_i(frame_ready), .frame_valid_o(frame_valid), .frame_byte_o(frame_byte),
    .frame_last_o(frame_last), .diag_pending_o(pend), .irq_o(irq));

  dpsd_engine_model i_dpsd_engine_model (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .poll_i(poll), .slow_i(slow), .frame_valid_i(frame_valid), .frame_byte_i(frame_byte),
    .frame_last_i(frame_last), .diag_req_o(diag_req), .frame_ready_o(frame_ready),
    .rx_o(rx), .len_o(len), .frames_o(frames));

  // ==========================================================================
  // Model, compare and bus tasks
  // ==========================================================================
  function automatic logic [7:0] eb(input int n);
    logic ext;
    ext = uv | (err != 3'h0);
    case (n)
      0: return {1'b0, fl[3], 1'b0, fl[2], ext, fl[1], fl[0], 1'b0};
      1: return {2'b00, fl[8], fl[7], fl[6], 1'b1, fl[5], fl[4]};
      2: return {fl[9], 7'h00};
      3: return ma;
      4: return idn[15:8];
      5: return idn[7:0];
      6: return 8'h0A;
      7: return (err != 3'h0) ? 8'h11 + 8'(err) : (uv ? 8'h40 : 8'h00);
      default: return (n > 10) ? 8'(mu[n - 11]) : 8'h00;
    endcase
  endfunction

  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t value %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // The request holds until ack is sampled high; read data is taken at that edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dw <= d;
    @(posedge clock_i);
    while (wb_ack !== 1'b1) @(posedge clock_i);
    q = wb_dr;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic poll_frame();
    int f0;
    f0 = frames;
    poll <= 1'b1;
    @(posedge clock_i);
    poll <= 1'b0;
    while (frames == f0) @(posedge clock_i);
    cmp_val(32'(len), 32'h10);
    for (int n = 0; n < 16; n++) begin
      cmp_val(32'(rx[n]), 32'(eb(n)));
    end
  endtask

  // ==========================================================================
  // Main sequence and hang guard
  // ==========================================================================
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("BAD %0t run did not finish", $time);
      results();
    end
  end

  initial begin
    void'($urandom(5235));
    repeat (8) @(posedge clock_i);
    rst_n_i <= 1'b1;
    @(posedge clock_i);
    cmp_bit(frame_valid, 1'b0);
    cmp_bit(irq, 1'b0);
    wb(1'b0, DPSD_OFS_IDENT, 32'h0);
    cmp_val(q, {16'h0, DPSD_IDENT_RESET});
    wb(1'b1, 8'h3C, 32'hFF);
    wb(1'b0, 8'h3C, 32'h0);
    cmp_val(q, 32'h0);
    idn = 16'($urandom);
    wb(1'b1, DPSD_OFS_IDENT, {16'h0, idn});
    for (int k = 0; k < 5; k++) begin
      mu[k] = $urandom_range(255, 0);
      wb(1'b1, DPSD_OFS_USER0 + 8'(4 * k), 32'(mu[k]));
    end
    wb(1'b0, DPSD_OFS_USER4, 32'h0);
    cmp_val(q, 32'(mu[4]));
    wb(1'b1, DPSD_OFS_IRQ_MASK, 32'hF);
    wb(1'b1, DPSD_OFS_IRQ_STAT, 32'hF);
    // Error codes 0 to 6, with random station flags and alternating engine speed.
    for (int i = 0; i < 7; i++) begin
      fl <= 10'($urandom);
      ma <= 8'($urandom);
      err <= 3'(i);
      slow <= i[0];
      repeat (4) @(posedge clock_i);
      cmp_bit(pend, i != 0);
      poll_frame();
      repeat (3) @(posedge clock_i);
      cmp_bit(pend, 1'b0);
      cmp_bit(irq, 1'b1);
      wb(1'b0, DPSD_OFS_IRQ_STAT, 32'h0);
      cmp_val(q & 32'h9, {28'h0, i != 0, 3'b001});
      wb(1'b1, DPSD_OFS_IRQ_STAT, 32'hF);
      @(posedge clock_i);
      cmp_bit(irq, 1'b0);
    end
    // Start by the CPU, then the ignored status value under a closed mask.
    err <= 3'h0;
    wb(1'b1, DPSD_OFS_DIAG_STAT, 32'h1);
    uv = 1'b1;
    repeat (2) @(posedge clock_i);
    cmp_bit(pend, 1'b1);
    wb(1'b0, DPSD_OFS_STATUS, 32'h0);
    cmp_val(q, {16'h0, DPSD_MSG_USER_VALID, 8'h03});
    poll_frame();
    wb(1'b1, DPSD_OFS_DIAG_STAT, 32'h0);
    uv = 1'b0;
    wb(1'b1, DPSD_OFS_IRQ_STAT, 32'hF);
    wb(1'b1, DPSD_OFS_IRQ_MASK, 32'h0);
    wb(1'b1, DPSD_OFS_DIAG_STAT, 32'h3);
    repeat (2) @(posedge clock_i);
    cmp_bit(pend, 1'b0);
    cmp_bit(irq, 1'b0);
    wb(1'b0, DPSD_OFS_DIAG_STAT, 32'h0);
    cmp_val(q, 32'h0);
    wb(1'b0, DPSD_OFS_IRQ_STAT, 32'h0);
    cmp_val(q & 32'h4, 32'h4);
    wb(1'b1, DPSD_OFS_IRQ_MASK, 32'h4);
    @(posedge clock_i);
    cmp_bit(irq, 1'b1);
    wb(1'b1, DPSD_OFS_IRQ_STAT, 32'h4);
    @(posedge clock_i);
    cmp_bit(irq, 1'b0);
    // A new error code while the clock enable is low must wait for it to return.
    ce <= 1'b0;
    err <= 3'h5;
    repeat (4) @(posedge clock_i);
    cmp_bit(pend, 1'b0);
    ce <= 1'b1;
    repeat (2) @(posedge clock_i);
    cmp_bit(pend, 1'b1);
    poll_frame();
    results();
  end
endmodule // tb_top
`default_nettype wire
